// ---- verilog/flash_cmd_defs.svh ----
// constants for the flash command checking and sequencing block
`ifndef FLASH_CMD_DEFS_SVH
`define FLASH_CMD_DEFS_SVH
`define CMD_ERASE_ALL       8'h08
`define CMD_UNSECURE        8'h0B
`define CMD_USER_MARGIN     8'h0D
`define CMD_FIELD_MARGIN    8'h0E
`define CMD_FULL_PARTITION  8'h0F
`define CMD_ERASE_VERIFY    8'h10
`define CMD_PROGRAM_DF      8'h11
`define CMD_ERASE_SECTOR    8'h12
`define CMD_EEE_ENABLE      8'h13
`define CMD_EEE_DISABLE     8'h14
`define CMD_EEE_QUERY       8'h15
`define CMD_PARTITION_DF    8'h20
`define IDX_MIN_PROGRAM     3'h2
`define IDX_MAX_PROGRAM     3'h5
`define IDX_ADDR_HI         3'h0
`define IDX_ADDR_LO         3'h1
`define DIV_RESET           7'h00
`define ADDR_WORD_BIT       0
`define DF_BLOCK_ID         7'h10
`define DF_BLOCK_BASE       23'h100000
`define DF_BLOCK_END        23'h107FFF
`define DF_SECTOR_MASK      23'h7FFF00
`define FCLK_PRESCALE       8'h04
`define ERASE_FCLK_TICKS    16'h0100
`define PROGRAM_FCLK_TICKS  16'h0020
`define VERIFY_FCLK_TICKS   16'h0008
`endif

// ---- verilog/flash_cmd_pkg.sv ----
// types for the flash command checking and sequencing block
package flash_cmd_pkg;
  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b000,
    ST_CHECK  = 3'b001,
    ST_RUN    = 3'b011,
    ST_VERIFY = 3'b010,
    ST_DONE   = 3'b110
  } seq_state_e;

  typedef struct packed
  {
    logic       access_error_flag;
    logic       protection_violation_flag;
    logic       command_complete_flag;
    logic       verify_error_status;
    logic       verify_fatal_error_status;
  } flash_status_s;

  typedef struct packed
  {
    logic       single_fault_detect_flag;
    logic       double_fault_detect_flag;
    logic [22:0] capture_addr;
    logic [15:0] capture_data;
    logic [5:0]  capture_parity;
  } ecc_capture_s;
endpackage

// ---- verilog/flash_cmd_check_sector_erase.sv ----
// flash command checker and sector erase / program sequencer
//
// Function
// [RULE1] program or erase before divider written sets access error, command dropped
// [RULE2] unsupported command code sets access error, sequence dropped
// [RULE3] reading the busy block returns invalid data, not array contents
// [RULE4] such read sets both fault flags if neither set, captures address, zero data
// [RULE5] software clears access error and protection flags before new sequence
// [RULE6] program with object index below 010 or above 101 sets access error
// [RULE7] program launched while load-data-field sequence active sets access error
// [RULE8] command not allowed in current mode sets access error
// [RULE9] invalid global address or odd word address sets access error
// [RULE10] address in emulated eeprom or group past block end sets access error
// [RULE11] verify sets error status on any error, fatal status on uncorrectable
// [RULE12] sector erase clears every address of one user-partition sector only
// [RULE13] software puts code 0x12 and block address bits at index 000
// [RULE14] software puts lower address bits of the sector at index 001
// [RULE15] launch erases and verifies sector, then sets command complete
// [RULE16] divider-loaded bit sets on first divider write; gates program and erase; code ignores a divider write made while command complete is low
// [RULE17] launches while command complete is low are ignored
`include "flash_cmd_defs.svh"

module flash_cmd_check_sector_erase
  import flash_cmd_pkg::*;
(
  // clock and reset
  input  wire logic          core_clk_in,
  input  wire logic          resetn_in,
  // divider register
  input  wire logic          div_wr_in,
  input  wire logic [6:0]    div_wdata_in,
  output logic      [7:0]    flash_clock_divider_reg_out,
  // command object
  input  wire logic [7:0]    cmd_code_in,
  input  wire logic [22:0]   cmd_addr_in,
  input  wire logic [2:0]    command_object_index_in,
  input  wire logic [1:0]    word_count_in,
  input  wire logic          launch_in,
  input  wire logic          load_data_active_in,
  input  wire logic          special_mode_in,
  input  wire logic [22:0]   eee_base_in,
  // status clears, write one to clear
  input  wire logic          clear_access_error_in,
  input  wire logic          clear_protection_in,
  input  wire logic          clear_faults_in,
  // array and verify results
  input  wire logic          verify_fail_in,
  input  wire logic          verify_fatal_in,
  // read port
  input  wire logic          rd_en_in,
  input  wire logic [22:0]   rd_addr_in,
  input  wire logic [15:0]   array_data_in,
  output logic      [15:0]   rd_data_out,
  // status and array control
  output flash_status_s      flash_status_reg_out,
  output ecc_capture_s       ecc_error_capture_regs_out,
  output logic               array_erase_out,
  output logic               array_program_out,
  output logic      [22:0]   array_addr_out
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic in_block(input logic [22:0] a);
    in_block = (a >= `DF_BLOCK_BASE) && (a <= `DF_BLOCK_END);
  endfunction
  function automatic logic known_code(input logic [7:0] c);
    case (c)
      `CMD_ERASE_ALL, `CMD_UNSECURE, `CMD_USER_MARGIN, `CMD_FIELD_MARGIN,
      `CMD_FULL_PARTITION, `CMD_ERASE_VERIFY, `CMD_PROGRAM_DF,
      `CMD_ERASE_SECTOR, `CMD_EEE_ENABLE, `CMD_EEE_DISABLE,
      `CMD_EEE_QUERY, `CMD_PARTITION_DF:
        known_code = 1'b1;
      default:
        known_code = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  seq_state_e    state_r, state_nxt;
  logic [6:0]    div_r, div_nxt;
  logic          divld_r, divld_nxt;
  flash_status_s stat_r, stat_nxt;
  ecc_capture_s  ecc_r, ecc_nxt;
  logic [7:0]    code_r, code_nxt;
  logic [22:0]   addr_r, addr_nxt;
  logic [22:0]   end_r, end_nxt;
  logic [7:0]    pre_r, pre_nxt;
  logic [15:0]   ticks_r, ticks_nxt;
  logic [15:0]   rd_data_r, rd_data_nxt;
  logic          is_prog;
  logic          is_erase;
  logic          bad;
  logic [22:0]   last_addr;
  logic          busy_hit;
  always_comb
  begin
    is_prog   = (cmd_code_in == `CMD_PROGRAM_DF);
    is_erase  = (cmd_code_in == `CMD_ERASE_SECTOR);
    last_addr = cmd_addr_in + {20'h00000, word_count_in, 1'b0};
    bad       = 1'b0;
    if ((is_prog || is_erase || cmd_code_in == `CMD_ERASE_ALL) && !divld_r)
      bad = 1'b1;                                               // RULE1 RULE16
    if (!known_code(cmd_code_in))
      bad = 1'b1;                                               // RULE2
    if (cmd_code_in == `CMD_FIELD_MARGIN && !special_mode_in)
      bad = 1'b1;                                               // RULE8
    if (is_prog)
    begin
      if (command_object_index_in < `IDX_MIN_PROGRAM ||
          command_object_index_in > `IDX_MAX_PROGRAM)
        bad = 1'b1;                                             // RULE6
      if (load_data_active_in)
        bad = 1'b1;                                             // RULE7
      if (!in_block(cmd_addr_in) || cmd_addr_in[`ADDR_WORD_BIT])
        bad = 1'b1;                                             // RULE9
      if (cmd_addr_in >= eee_base_in || !in_block(last_addr) ||
          last_addr >= eee_base_in)
        bad = 1'b1;                                             // RULE10
    end
    if (is_erase && (cmd_addr_in[22:16] != `DF_BLOCK_ID ||
        !in_block(cmd_addr_in) || cmd_addr_in >= eee_base_in))
      bad = 1'b1;                                               // RULE12
  end

  // limitation: the whole data-flash block is treated as one busy target
  assign busy_hit = rd_en_in && !stat_r.command_complete_flag && in_block(rd_addr_in);
  always_comb
  begin
    state_nxt   = state_r;
    div_nxt     = div_r;
    divld_nxt   = divld_r;
    stat_nxt    = stat_r;
    ecc_nxt     = ecc_r;
    code_nxt    = code_r;
    addr_nxt    = addr_r;
    end_nxt     = end_r;
    pre_nxt     = pre_r;
    ticks_nxt   = ticks_r;
    rd_data_nxt = rd_data_r;
    // divider is write once and held steady while a command runs
    if (div_wr_in && !divld_r && stat_r.command_complete_flag)
    begin
      div_nxt   = div_wdata_in;
      divld_nxt = 1'b1;                                         // RULE16
    end
    if (clear_access_error_in)
      stat_nxt.access_error_flag = 1'b0;
    if (clear_protection_in)
      stat_nxt.protection_violation_flag = 1'b0;
    if (clear_faults_in)
    begin
      ecc_nxt.single_fault_detect_flag = 1'b0;
      ecc_nxt.double_fault_detect_flag = 1'b0;
    end
    // reads: invalid data while own algorithm runs
    if (rd_en_in)
      rd_data_nxt = busy_hit ? 16'h0000 : array_data_in;        // RULE3
    if (busy_hit && !ecc_r.single_fault_detect_flag && !ecc_r.double_fault_detect_flag)
    begin
      ecc_nxt.single_fault_detect_flag = 1'b1;                  // RULE4
      ecc_nxt.double_fault_detect_flag = 1'b1;
      ecc_nxt.capture_addr             = rd_addr_in;
      ecc_nxt.capture_data             = 16'h0000;
      ecc_nxt.capture_parity           = 6'h00;
    end
    // fclk tick from divided clock
    if (state_r == ST_RUN || state_r == ST_VERIFY)
      pre_nxt = (pre_r == 8'h00) ? ({1'b0, div_r} + `FCLK_PRESCALE) : pre_r - 8'h01;
    case (state_r)
      ST_IDLE:
      begin
        // software must have cleared old errors first; a stale flag blocks launch
        if (launch_in && stat_r.command_complete_flag &&            // RULE17
            !stat_r.access_error_flag && !stat_r.protection_violation_flag) // RULE5
        begin
          if (bad)
            stat_nxt.access_error_flag = 1'b1;                  // RULE2
          else
          begin
            stat_nxt.command_complete_flag     = 1'b0;
            stat_nxt.verify_error_status       = 1'b0;
            stat_nxt.verify_fatal_error_status = 1'b0;
            code_nxt  = cmd_code_in;
            addr_nxt  = is_erase ? (cmd_addr_in & `DF_SECTOR_MASK) : cmd_addr_in; // RULE13 RULE14
            end_nxt   = is_erase ? ((cmd_addr_in & `DF_SECTOR_MASK) | 23'h0000FF)
                                 : last_addr;
            ticks_nxt = is_erase ? `ERASE_FCLK_TICKS : `PROGRAM_FCLK_TICKS;
            pre_nxt   = {1'b0, div_r};
            state_nxt = ST_CHECK;
          end
        end
      end
      ST_CHECK:
        state_nxt = ST_RUN;
      ST_RUN:
      begin
        if (pre_r == 8'h00)
        begin
          if (ticks_r == 16'h0000)
          begin
            ticks_nxt = `VERIFY_FCLK_TICKS;
            state_nxt = ST_VERIFY;                              // RULE15
          end
          else
            ticks_nxt = ticks_r - 16'h0001;
        end
      end
      ST_VERIFY:
      begin
        if (verify_fail_in)
          stat_nxt.verify_error_status = 1'b1;                  // RULE11
        if (verify_fatal_in)
          stat_nxt.verify_fatal_error_status = 1'b1;            // RULE11
        if (pre_r == 8'h00)
        begin
          if (ticks_r == 16'h0000)
            state_nxt = ST_DONE;
          else
            ticks_nxt = ticks_r - 16'h0001;
        end
      end
      ST_DONE:
      begin
        stat_nxt.command_complete_flag = 1'b1;                  // RULE15
        state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r   <= ST_IDLE;
      div_r     <= `DIV_RESET;
      divld_r   <= 1'b0;
      stat_r    <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
      ecc_r     <= '0;
      code_r    <= 8'h00;
      addr_r    <= 23'h000000;
      end_r     <= 23'h000000;
      pre_r     <= 8'h00;
      ticks_r   <= 16'h0000;
      rd_data_r <= 16'h0000;
    end
    else
    begin
      state_r   <= state_nxt;
      div_r     <= div_nxt;
      divld_r   <= divld_nxt;
      stat_r    <= stat_nxt;
      ecc_r     <= ecc_nxt;
      code_r    <= code_nxt;
      addr_r    <= addr_nxt;
      end_r     <= end_nxt;
      pre_r     <= pre_nxt;
      ticks_r   <= ticks_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign flash_clock_divider_reg_out = {divld_r, div_r};
  assign flash_status_reg_out        = stat_r;
  assign ecc_error_capture_regs_out  = ecc_r;
  assign rd_data_out                 = rd_data_r;
  assign array_erase_out   = (state_r == ST_RUN) && (code_r == `CMD_ERASE_SECTOR); // RULE12
  assign array_program_out = (state_r == ST_RUN) && (code_r == `CMD_PROGRAM_DF);
  assign array_addr_out    = (state_r == ST_RUN) ? addr_r : end_r;

endmodule

// ---- dv/flash_cmd_chk.sv ----
// assertion checker for the flash command block
`include "flash_cmd_defs.svh"
module flash_cmd_chk
  import flash_cmd_pkg::*;
(
  // clock, reset and inputs
  input wire logic          core_clk_in,
  input wire logic          resetn_in,
  input wire logic          div_wr_in,
  input wire logic [6:0]    div_wdata_in,
  input wire logic [7:0]    cmd_code_in,
  input wire logic [22:0]   cmd_addr_in,
  input wire logic [2:0]    command_object_index_in,
  input wire logic          launch_in,
  input wire logic          rd_en_in,
  input wire logic [22:0]   rd_addr_in,
  input wire logic [15:0]   array_data_in,
  // outputs
  input wire logic [7:0]    flash_clock_divider_reg_out,
  input wire logic [15:0]   rd_data_out,
  input wire flash_status_s flash_status_reg_out,
  input wire ecc_capture_s  ecc_error_capture_regs_out,
  input wire logic          array_erase_out
);
  // ---------------
  // helpers
  // ---------------
  flash_status_s s;
  ecc_capture_s  e;
  logic          go;
  logic          blk;
  assign s = flash_status_reg_out;
  assign e = ecc_error_capture_regs_out;
  assign go = launch_in && s.command_complete_flag && !s.access_error_flag
              && !s.protection_violation_flag;
  // only the data-flash block exists, so any read in it while busy hits the busy block
  assign blk = rd_en_in && !s.command_complete_flag && rd_addr_in >= `DF_BLOCK_BASE
               && rd_addr_in <= `DF_BLOCK_END;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);
  property p_div_load;
    div_wr_in && s.command_complete_flag && !flash_clock_divider_reg_out[7]
      |=> flash_clock_divider_reg_out == {1'b1, $past(div_wdata_in)};
  endproperty
  a_div_load: assert property (p_div_load) else $error("divider load wrong");
  property p_no_div;
    go && !flash_clock_divider_reg_out[7] && cmd_code_in inside {8'h11, 8'h12}
      |=> s.access_error_flag;
  endproperty
  a_no_div: assert property (p_no_div) else $error("launch without divider");
  property p_bad_code;
    go && !(cmd_code_in inside {8'h08, 8'h0B, [8'h0D:8'h15], 8'h20})
      |=> s.access_error_flag && s.command_complete_flag;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code accepted");
  property p_busy_rd;
    blk |=> rd_data_out == 16'h0000;
  endproperty
  a_busy_rd: assert property (p_busy_rd) else $error("busy read gave data");
  property p_fault;
    blk && !e.single_fault_detect_flag && !e.double_fault_detect_flag
      |=> e.single_fault_detect_flag && e.double_fault_detect_flag
          && e.capture_addr == $past(rd_addr_in) && e.capture_data == 16'h0000
          && e.capture_parity == 6'h00;
  endproperty
  a_fault: assert property (p_fault) else $error("fault capture wrong");
  property p_idx;
    go && cmd_code_in == 8'h11 && !(command_object_index_in inside {[3'h2:3'h5]})
      |=> s.access_error_flag;
  endproperty
  a_idx: assert property (p_idx) else $error("index not refused");
  property p_odd;
    go && cmd_code_in == 8'h11 && cmd_addr_in[0] |=> s.access_error_flag;
  endproperty
  a_odd: assert property (p_odd) else $error("odd address accepted");
  property p_ignore;
    launch_in && !s.command_complete_flag && !s.access_error_flag
      |=> !s.access_error_flag ##1 !s.access_error_flag;
  endproperty
  a_ignore: assert property (p_ignore) else $error("busy launch not ignored");
  cover property (go && cmd_code_in == 8'h12 ##2 array_erase_out);
  cover property (blk);
  cover property (go ##1 s.access_error_flag);
endmodule

bind flash_cmd_check_sector_erase flash_cmd_chk u_chk
(
  .core_clk_in                 (core_clk_in),
  .resetn_in                   (resetn_in),
  .div_wr_in                   (div_wr_in),
  .div_wdata_in                (div_wdata_in),
  .cmd_code_in                 (cmd_code_in),
  .cmd_addr_in                 (cmd_addr_in),
  .command_object_index_in     (command_object_index_in),
  .launch_in                   (launch_in),
  .rd_en_in                    (rd_en_in),
  .rd_addr_in                  (rd_addr_in),
  .array_data_in               (array_data_in),
  .flash_clock_divider_reg_out (flash_clock_divider_reg_out),
  .rd_data_out                 (rd_data_out),
  .flash_status_reg_out        (flash_status_reg_out),
  .ecc_error_capture_regs_out  (ecc_error_capture_regs_out),
  .array_erase_out             (array_erase_out)
);

// ---- dv/tb_top.sv ----
// self-checking bench for the flash command block
module tb_top
  import flash_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          core_clk_in, resetn_in, div_wr_in, launch_in, load_data_active_in;
  logic          special_mode_in, clear_access_error_in, clear_protection_in;
  logic          clear_faults_in, verify_fail_in, verify_fatal_in, rd_en_in;
  logic          array_erase_out, array_program_out;
  logic [1:0]    word_count_in;
  logic [2:0]    command_object_index_in;
  logic [6:0]    div_wdata_in;
  logic [7:0]    cmd_code_in, flash_clock_divider_reg_out;
  logic [15:0]   array_data_in, rd_data_out;
  logic [22:0]   cmd_addr_in, eee_base_in, rd_addr_in, array_addr_out;
  flash_status_s flash_status_reg_out;
  ecc_capture_s  ecc_error_capture_regs_out;
  int            n_errors = 0;
  int            total_checks = 0;
  int            cyc = 0;

  flash_cmd_check_sector_erase dut
  (
    .core_clk_in                 (core_clk_in),
    .resetn_in                   (resetn_in),
    .div_wr_in                   (div_wr_in),
    .div_wdata_in                (div_wdata_in),
    .flash_clock_divider_reg_out (flash_clock_divider_reg_out),
    .cmd_code_in                 (cmd_code_in),
    .cmd_addr_in                 (cmd_addr_in),
    .command_object_index_in     (command_object_index_in),
    .word_count_in               (word_count_in),
    .launch_in                   (launch_in),
    .load_data_active_in         (load_data_active_in),
    .special_mode_in             (special_mode_in),
    .eee_base_in                 (eee_base_in),
    .clear_access_error_in       (clear_access_error_in),
    .clear_protection_in         (clear_protection_in),
    .clear_faults_in             (clear_faults_in),
    .verify_fail_in              (verify_fail_in),
    .verify_fatal_in             (verify_fatal_in),
    .rd_en_in                    (rd_en_in),
    .rd_addr_in                  (rd_addr_in),
    .array_data_in               (array_data_in),
    .rd_data_out                 (rd_data_out),
    .flash_status_reg_out        (flash_status_reg_out),
    .ecc_error_capture_regs_out  (ecc_error_capture_regs_out),
    .array_erase_out             (array_erase_out),
    .array_program_out           (array_program_out),
    .array_addr_out              (array_addr_out)
  );

  always #2 core_clk_in = ~core_clk_in;
  // two long commands at most, each well below a few thousand cycles
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] c, input logic [22:0] a, input logic [2:0] ix,
                     input logic [1:0] wc);
    @(negedge core_clk_in);
    cmd_code_in = c;
    cmd_addr_in = a;
    command_object_index_in = ix;
    word_count_in = wc;
    launch_in = 1'b1;
    @(negedge core_clk_in);
    launch_in = 1'b0;
  endtask

  // refused launch: flag stands, no run starts, then software clears it
  task automatic bad(input logic [7:0] c, input logic [22:0] a, input logic [2:0] ix,
                     input logic [1:0] wc);
    cmd(c, a, ix, wc);
    @(negedge core_clk_in);
    chk(32'(flash_status_reg_out), 32'h14);
    clear_access_error_in = 1'b1;
    @(negedge core_clk_in);
    clear_access_error_in = 1'b0;
    @(negedge core_clk_in);
    chk(32'(flash_status_reg_out.access_error_flag), 32'h0);
  endtask

  task automatic rd(input logic [22:0] a, input logic [15:0] d);
    @(negedge core_clk_in);
    rd_en_in = 1'b1;
    rd_addr_in = a;
    array_data_in = d;
    @(negedge core_clk_in);
    rd_en_in = 1'b0;
  endtask

  task automatic wait_done();
    for (int i = 0; i < 30000 && !flash_status_reg_out.command_complete_flag; i++)
      @(negedge core_clk_in);
    chk(32'(flash_status_reg_out.command_complete_flag), 32'h1);
  endtask

  initial
  begin
    core_clk_in = 1'b0;
    resetn_in = 1'b0;
    {div_wr_in, launch_in, load_data_active_in, special_mode_in, clear_access_error_in,
     clear_protection_in, clear_faults_in, verify_fail_in, verify_fatal_in, rd_en_in,
     word_count_in, command_object_index_in, div_wdata_in, cmd_code_in, array_data_in,
     cmd_addr_in, rd_addr_in} = '0;
    eee_base_in = 23'h104000;
    repeat (16) @(negedge core_clk_in);
    resetn_in = 1'b1;
    repeat (4) @(negedge core_clk_in);
    chk(32'(flash_status_reg_out), 32'h04);
    chk(32'(flash_clock_divider_reg_out), 32'h00);
    bad(8'h12, 23'h100000, 3'h1, 2'h0);
    for (int i = 0; i < 2; i++)
    begin
      div_wdata_in = i ? 7'h05 : 7'h01;
      div_wr_in = 1'b1;
      @(negedge core_clk_in);
      div_wr_in = 1'b0;
      @(negedge core_clk_in);
      chk(32'(flash_clock_divider_reg_out), 32'h81);
    end
    bad(8'h55, 23'h100000, 3'h1, 2'h0);
    bad(8'h11, 23'h100000, 3'h1, 2'h0);
    bad(8'h11, 23'h100000, 3'h6, 2'h0);
    load_data_active_in = 1'b1;
    bad(8'h11, 23'h100000, 3'h2, 2'h0);
    load_data_active_in = 1'b0;
    bad(8'h0E, 23'h100000, 3'h2, 2'h0);
    bad(8'h11, 23'h100001, 3'h2, 2'h0);
    bad(8'h11, 23'h200000, 3'h2, 2'h0);
    bad(8'h11, 23'h104000, 3'h2, 2'h0);
    bad(8'h11, 23'h103FFC, 3'h5, 2'h3);
    eee_base_in = 23'h7FFFFF;
    bad(8'h11, 23'h107FFE, 3'h5, 2'h3);
    eee_base_in = 23'h104000;
    {verify_fail_in, verify_fatal_in} = 2'b11;
    cmd(8'h11, 23'h100000, 3'h2, 2'h0);
    @(negedge core_clk_in);
    chk(32'({flash_status_reg_out.command_complete_flag, array_program_out}), 32'h1);
    wait_done();
    chk(32'(flash_status_reg_out), 32'h07);
    {verify_fail_in, verify_fatal_in} = 2'b00;
    cmd(8'h12, 23'h100123, 3'h1, 2'h0);
    repeat (2) @(negedge core_clk_in);
    chk(32'({flash_status_reg_out.command_complete_flag, array_erase_out}), 32'h1);
    chk(32'(array_addr_out), 32'h100100);
    cmd(8'h55, 23'h100000, 3'h1, 2'h0);
    @(negedge core_clk_in);
    chk(32'(flash_status_reg_out), 32'h00);
    chk(32'({flash_status_reg_out.command_complete_flag, array_erase_out}), 32'h1);
    rd(23'h100010, 16'hBEEF);
    chk(32'(rd_data_out), 32'h0);
    chk(32'(ecc_error_capture_regs_out >> 22), {7'h0, 2'b11, 23'h100010});
    chk(32'(ecc_error_capture_regs_out[21:0]), 32'h0);
    rd(23'h100020, 16'h1234);
    chk(32'(ecc_error_capture_regs_out[44:22]), 32'h100010);
    wait_done();
    rd(23'h100010, 16'hBEEF);
    chk(32'(rd_data_out), 32'hBEEF);
    clear_faults_in = 1'b1;
    @(negedge core_clk_in);
    clear_faults_in = 1'b0;
    chk(32'(ecc_error_capture_regs_out[46:45]), 32'h0);
    print_verdict();
  end
endmodule
